/* src/tola_pkg.sv */
// How it works
// - Alarm enable bit; when off, no alarm pickup, timeout or alarm output.
// - Alarm level 0.60..0.99 of capacity used, default 0.70, only with alarm on.
// - Alarm delay 1..360 whole minutes, default 1, only with alarm on.
// - Current above ultimate trip level grows capacity and raises overload flag.
// - Sensor-in-use flag needs overload, sensor enable and a valid reading above 0.
// - Two external block inputs shown as input states, able to block the model.
// - Separate external input blocks only the trip order, alarm keeps running.
// - Status outputs: active, blocked, trip blocks, alarm, trip and trip order.
// - Separate alarm pickup and alarm timeout outputs.
// - External block acts only with block allowed and input assigned.
// - Trip level 0.60..0.99 default 0.99; trip delay 0.0..3600.0 seconds.
// - Permanent trip-order block suppresses the trip order regardless of inputs.
package tola_pkg;

  // ------------------------------------
  // Register map
  // ------------------------------------
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_ALARM_LVL = 8'h04;
  localparam logic [7:0] OFS_ALARM_DLY = 8'h08;
  localparam logic [7:0] OFS_TRIP_LVL  = 8'h0c;
  localparam logic [7:0] OFS_TRIP_DLY  = 8'h10;
  localparam logic [7:0] OFS_ULT_LVL   = 8'h14;
  localparam logic [7:0] OFS_STATUS    = 8'h18;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h1c;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h20;
  localparam logic [7:0] OFS_CAPACITY  = 8'h24;
  localparam logic [7:0] OFS_CMD       = 8'h28;

  // ------------------------------------
  // Control fields
  // ------------------------------------
  localparam int CTRL_FUNC_EN     = 0;
  localparam int CTRL_ALARM_EN    = 1;
  localparam int CTRL_TRIP_EN     = 2;
  localparam int CTRL_BLOCK_ALLOW = 3;
  localparam int CTRL_PERM_BLOCK  = 4;
  localparam int CTRL_TBLK_ALLOW  = 5;
  localparam int CTRL_SENSOR_EN   = 6;
  localparam int CTRL_ASSIGN_A    = 7;
  localparam int CTRL_ASSIGN_B    = 8;
  localparam int CTRL_ASSIGN_T    = 9;
  localparam int CTRL_W           = 10;
  localparam int CMD_CLEAR_CAP    = 0;

  localparam logic [CTRL_W-1:0] CTRL_RST = 10'h007;

  // ------------------------------------
  // Settings: levels in hundredths, delays in minutes or tenths of seconds
  // ------------------------------------
  localparam logic [6:0]  LVL_MIN        = 7'h3c;
  localparam logic [6:0]  LVL_MAX        = 7'h63;
  localparam logic [6:0]  ALARM_LVL_RST  = 7'h46;
  localparam logic [6:0]  TRIP_LVL_RST   = 7'h63;
  localparam logic [8:0]  ALARM_DLY_MIN  = 9'h001;
  localparam logic [8:0]  ALARM_DLY_MAX  = 9'h168;
  localparam logic [8:0]  ALARM_DLY_RST  = 9'h001;
  localparam logic [15:0] TRIP_DLY_MAX   = 16'h8ca0;
  localparam logic [15:0] TRIP_DLY_RST   = 16'h0000;
  localparam logic [15:0] ULT_LVL_RST    = 16'h0100;

  // Capacity held in hundredths of a percent, 0..1000 %
  localparam int          CAP_W          = 17;
  localparam logic [16:0] CAP_MAX        = 17'h186a0;
  localparam logic [16:0] CAP_PER_LVL    = 17'h00064;
  localparam logic [16:0] CAP_STEP_RST   = 17'h00001;

  // ------------------------------------
  // Timing
  // ------------------------------------
  localparam int CLK_HZ        = 50_000_000;
  localparam int TICK_MS       = 1;
  localparam int TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
  localparam int MS_PER_MIN    = 60_000;
  localparam int MS_PER_TENTH  = 100;
  localparam int DLY_W         = 26;

  // ------------------------------------
  // Status layout and interrupt events
  // ------------------------------------
  typedef struct packed {
    logic tempSensorInUse;
    logic overloadAboveServiceFactor;
    logic alarmTimeout;
    logic alarmPickup;
    logic tripOrder;
    logic trip;
    logic alarm;
    logic tripOrderExtBlocked;
    logic tripOrderPermBlock;
    logic externallyBlocked;
    logic moduleActive;
  } tola_status_s;

  localparam int IRQ_W = 5;
  typedef struct packed {
    logic tripOrder;
    logic overload;
    logic trip;
    logic alarmTimeout;
    logic alarmPickup;
  } tola_irq_s;

endpackage

/* src/tola_delay.sv */
`timescale 1ns/100ps
module tola_delay
  import tola_pkg::*;
#(
  parameter int W = DLY_W
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         run,
  input  wire logic         msTick,
  input  wire logic [W-1:0] targetMs,
  output logic              done
);

  logic [W-1:0] count_reg;
  logic         done_reg;

  // Count restarts whenever the run condition drops
  always_ff @(posedge clk) begin
    if (rst || !run) begin
      count_reg <= '0;
    end else if (msTick && count_reg < targetMs) begin
      count_reg <= count_reg + W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst || !run) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= (count_reg >= targetMs);
    end
  end

  assign done = done_reg & run;

endmodule

/* src/tola_top.sv */
`timescale 1ns/100ps
module tola_top
  import tola_pkg::*;
#(
  parameter int          N_SENSORS  = 2,
  parameter int          TEMP_W     = 12,
  parameter int          CUR_W      = 16,
  parameter int          TICK_CYC   = TICK_CYCLES,
  parameter logic [16:0] CAP_STEP   = CAP_STEP_RST
) (
  input  wire logic                        clk,
  input  wire logic                        rst,
  // APB
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [7:0]                  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic [31:0]                      prdata,
  output logic                             pready,
  output logic                             pslverr,
  // Measurement and assigned signals
  input  wire logic [CUR_W-1:0]            phaseCurrent,
  input  wire logic [N_SENSORS-1:0]        tempValid,
  input  wire logic [N_SENSORS*TEMP_W-1:0] tempValue,
  input  wire logic                        extBlockInA,
  input  wire logic                        extBlockInB,
  input  wire logic                        extTripOrderBlock,
  // Status
  output tola_status_s                     status,
  output logic [2:0]                       inputStates,
  output logic [CAP_W-1:0]                 thermalCapacityUsed,
  output logic                             irq
);

  // ------------------------------------
  // Helpers
  // ------------------------------------
  function automatic logic [6:0] clampLvl(input logic [31:0] v);
    if (v[31:7] != '0 || v[6:0] > LVL_MAX) begin
      return LVL_MAX;
    end else if (v[6:0] < LVL_MIN) begin
      return LVL_MIN;
    end
    return v[6:0];
  endfunction

  function automatic logic [8:0] clampMin(input logic [31:0] v);
    if (v[31:9] != '0 || v[8:0] > ALARM_DLY_MAX) begin
      return ALARM_DLY_MAX;
    end else if (v[8:0] < ALARM_DLY_MIN) begin
      return ALARM_DLY_MIN;
    end
    return v[8:0];
  endfunction

  function automatic logic [CAP_W-1:0] lvlToCap(input logic [6:0] lvl);
    return CAP_W'(lvl) * CAP_PER_LVL;
  endfunction

  // ------------------------------------
  // Bus decode
  // ------------------------------------
  logic setupPhase;
  logic wrEn;
  logic mapped;

  assign setupPhase = psel & ~penable;
  assign wrEn       = psel & penable & pwrite;
  assign pready     = 1'b1;

  always_comb begin
    case (paddr)
      OFS_CTRL, OFS_ALARM_LVL, OFS_ALARM_DLY, OFS_TRIP_LVL, OFS_TRIP_DLY,
      OFS_ULT_LVL, OFS_STATUS, OFS_IRQ_STAT, OFS_IRQ_MASK, OFS_CAPACITY,
      OFS_CMD: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign pslverr = psel & penable & ~mapped;

  // ------------------------------------
  // Settings registers
  // ------------------------------------
  logic [CTRL_W-1:0] ctrl_reg;
  logic [6:0]        alarmLvl_reg;
  logic [8:0]        alarmDly_reg;
  logic [6:0]        tripLvl_reg;
  logic [15:0]       tripDly_reg;
  logic [CUR_W-1:0]  ultLvl_reg;
  logic [IRQ_W-1:0]  irqMask_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_reg     <= CTRL_RST;
      alarmLvl_reg <= ALARM_LVL_RST;
      alarmDly_reg <= ALARM_DLY_RST;
      tripLvl_reg  <= TRIP_LVL_RST;
      tripDly_reg  <= TRIP_DLY_RST;
      ultLvl_reg   <= CUR_W'(ULT_LVL_RST);
      irqMask_reg  <= '0;
    end else if (wrEn) begin
      case (paddr)
        OFS_CTRL:      ctrl_reg     <= pwdata[CTRL_W-1:0];
        OFS_ALARM_LVL: alarmLvl_reg <= clampLvl(pwdata);
        OFS_ALARM_DLY: alarmDly_reg <= clampMin(pwdata);
        OFS_TRIP_LVL:  tripLvl_reg  <= clampLvl(pwdata);
        OFS_TRIP_DLY: begin
          // Out-of-range delay saturates at 3600.0 s
          tripDly_reg <= (pwdata[31:16] != '0 || pwdata[15:0] > TRIP_DLY_MAX) ?
                         TRIP_DLY_MAX : pwdata[15:0];
        end
        OFS_ULT_LVL:   ultLvl_reg   <= pwdata[CUR_W-1:0];
        OFS_IRQ_MASK:  irqMask_reg  <= pwdata[IRQ_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // ------------------------------------
  // Millisecond tick
  // ------------------------------------
  // One bit at least, so a one-cycle tick still has a counter
  localparam int TICK_W = (TICK_CYC > 1) ? $clog2(TICK_CYC) : 1;
  logic [TICK_W-1:0] tick_reg;
  logic              msTick;

  assign msTick = (tick_reg == $bits(tick_reg)'(TICK_CYC - 1));

  always_ff @(posedge clk) begin
    if (rst || msTick) begin
      tick_reg <= '0;
    end else begin
      tick_reg <= tick_reg + $bits(tick_reg)'(1);
    end
  end

  // ------------------------------------
  // Blocking
  // ------------------------------------
  logic funcEn;
  logic blocked;
  logic active;
  logic tripBlkExt;

  assign funcEn  = ctrl_reg[CTRL_FUNC_EN];
  // An unassigned input or a disallowed block leaves the model running
  assign blocked = funcEn & ctrl_reg[CTRL_BLOCK_ALLOW] &
                   ((extBlockInA & ctrl_reg[CTRL_ASSIGN_A]) |
                    (extBlockInB & ctrl_reg[CTRL_ASSIGN_B]));
  assign active  = funcEn & ~blocked;
  assign tripBlkExt = active & ctrl_reg[CTRL_TBLK_ALLOW] & ctrl_reg[CTRL_ASSIGN_T] &
                      extTripOrderBlock;

  // ------------------------------------
  // Thermal capacity used
  // ------------------------------------
  logic             overload;
  logic [CAP_W-1:0] cap_reg;
  logic [CAP_W-1:0] cap_next;
  logic             clearCmd;

  assign overload = funcEn & (phaseCurrent > ultLvl_reg);
  assign clearCmd = wrEn & (paddr == OFS_CMD) & pwdata[CMD_CLEAR_CAP];

  always_comb begin
    cap_next = cap_reg;
    if (overload && msTick) begin
      // Saturate at the top of the 0..1000 % range
      cap_next = (CAP_MAX - cap_reg < CAP_STEP) ? CAP_MAX : cap_reg + CAP_STEP;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || clearCmd) begin
      cap_reg <= '0;
    end else begin
      cap_reg <= cap_next;
    end
  end

  assign thermalCapacityUsed = cap_reg;

  // ------------------------------------
  // Temperature sensors
  // ------------------------------------
  logic [N_SENSORS-1:0] warmValid;

  generate
    for (genvar i = 0; i < N_SENSORS; i++) begin : g_sensor
      logic signed [TEMP_W-1:0] t;
      assign t            = tempValue[i*TEMP_W +: TEMP_W];
      assign warmValid[i] = tempValid[i] & (t > TEMP_W'(0));
    end
  endgenerate

  // ------------------------------------
  // Alarm and trip supervision
  // ------------------------------------
  logic             alarmOn;
  logic             alarmPick;
  logic             alarmDone;
  logic             tripPick;
  logic             tripDone;
  logic [DLY_W-1:0] alarmMs;
  logic [DLY_W-1:0] tripMs;

  assign alarmOn   = active & ctrl_reg[CTRL_ALARM_EN];
  assign alarmPick = alarmOn & (cap_reg >= lvlToCap(alarmLvl_reg));
  assign tripPick  = active & ctrl_reg[CTRL_TRIP_EN] &
                     (cap_reg >= lvlToCap(tripLvl_reg));
  assign alarmMs   = DLY_W'(alarmDly_reg) * DLY_W'(MS_PER_MIN);
  assign tripMs    = DLY_W'(tripDly_reg) * DLY_W'(MS_PER_TENTH);

  // Delay restarts when pickup drops or the block clears it
  tola_delay #(
    .W        (DLY_W)
  ) u_alarm_delay (
    .clk      (clk),
    .rst      (rst),
    .run      (alarmPick),
    .msTick   (msTick),
    .targetMs (alarmMs),
    .done     (alarmDone)
  );

  tola_delay #(
    .W        (DLY_W)
  ) u_trip_delay (
    .clk      (clk),
    .rst      (rst),
    .run      (tripPick),
    .msTick   (msTick),
    .targetMs (tripMs),
    .done     (tripDone)
  );

  // ------------------------------------
  // Status outputs
  // ------------------------------------
  tola_status_s st_next;
  tola_status_s st_reg;

  always_comb begin
    st_next                            = '0;
    st_next.moduleActive               = active;
    st_next.externallyBlocked          = blocked;
    st_next.tripOrderPermBlock         = active & ctrl_reg[CTRL_PERM_BLOCK];
    st_next.tripOrderExtBlocked        = tripBlkExt;
    st_next.alarmPickup                = alarmPick;
    st_next.alarmTimeout               = alarmPick & alarmDone;
    st_next.alarm                      = alarmPick & alarmDone;
    st_next.trip                       = tripPick & tripDone;
    // Trip stays visible even when only the order is held back
    st_next.tripOrder                  = tripPick & tripDone &
                                         ~ctrl_reg[CTRL_PERM_BLOCK] & ~tripBlkExt;
    st_next.overloadAboveServiceFactor = overload;
    st_next.tempSensorInUse            = overload & ctrl_reg[CTRL_SENSOR_EN] &
                                         (|warmValid);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      inputStates <= '0;
    end else begin
      inputStates <= {extTripOrderBlock, extBlockInB, extBlockInA};
    end
  end

  assign status = st_reg;

  // ------------------------------------
  // Interrupts
  // ------------------------------------
  tola_irq_s        ev;
  logic [IRQ_W-1:0] irqStat_reg;
  logic [IRQ_W-1:0] irqStat_next;
  logic [IRQ_W-1:0] irqClr;

  always_comb begin
    ev.alarmPickup  = st_next.alarmPickup & ~st_reg.alarmPickup;
    ev.alarmTimeout = st_next.alarmTimeout & ~st_reg.alarmTimeout;
    ev.trip         = st_next.trip & ~st_reg.trip;
    ev.overload     = st_next.overloadAboveServiceFactor &
                      ~st_reg.overloadAboveServiceFactor;
    ev.tripOrder    = st_next.tripOrder & ~st_reg.tripOrder;
  end

  assign irqClr       = (wrEn && paddr == OFS_IRQ_STAT) ? pwdata[IRQ_W-1:0] : '0;
  // A new event in the clearing cycle survives the clear
  assign irqStat_next = (irqStat_reg & ~irqClr) | ev;

  always_ff @(posedge clk) begin
    if (rst) begin
      irqStat_reg <= '0;
    end else begin
      irqStat_reg <= irqStat_next;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStat_next & irqMask_reg);
    end
  end

  // ------------------------------------
  // Read data
  // ------------------------------------
  logic [31:0] rd_next;

  always_comb begin
    case (paddr)
      OFS_CTRL:      rd_next = 32'(ctrl_reg);
      OFS_ALARM_LVL: rd_next = 32'(alarmLvl_reg);
      OFS_ALARM_DLY: rd_next = 32'(alarmDly_reg);
      OFS_TRIP_LVL:  rd_next = 32'(tripLvl_reg);
      OFS_TRIP_DLY:  rd_next = 32'(tripDly_reg);
      OFS_ULT_LVL:   rd_next = 32'(ultLvl_reg);
      OFS_STATUS:    rd_next = 32'({inputStates, st_reg});
      OFS_IRQ_STAT:  rd_next = 32'(irqStat_reg);
      OFS_IRQ_MASK:  rd_next = 32'(irqMask_reg);
      OFS_CAPACITY:  rd_next = 32'(cap_reg);
      default:       rd_next = 32'h0000_0000;
    endcase
  end

  // Captured in the setup cycle so prdata is a flop in the access cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata <= '0;
    end else if (setupPhase) begin
      prdata <= rd_next;
    end
  end

endmodule

/* dv/tola_assertions.sv */
`timescale 1ns/100ps
module tola_assertions
  import tola_pkg::*;
#(
  parameter int N_SENSORS = 2,
  parameter int TEMP_W    = 12,
  parameter int CUR_W     = 16
) (
  input wire logic                        clk,
  input wire logic                        rst,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [7:0]                  paddr,
  input wire logic [31:0]                 pwdata,
  input wire logic                        pready,
  input wire logic                        pslverr,
  input wire logic [CUR_W-1:0]            phaseCurrent,
  input wire logic [N_SENSORS-1:0]        tempValid,
  input wire logic [N_SENSORS*TEMP_W-1:0] tempValue,
  input wire logic                        extBlockInA,
  input wire logic                        extBlockInB,
  input wire logic                        extTripOrderBlock,
  input wire tola_status_s                status,
  input wire logic [2:0]                  inputStates,
  input wire logic [CAP_W-1:0]            thermalCapacityUsed
);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Limitation: assumes the ultimate level keeps its reset value
  logic       overCur;
  logic       clrReq;
  logic       anyHot;
  logic [2:0] inNow;
  assign overCur = phaseCurrent > CUR_W'(ULT_LVL_RST);
  assign clrReq  = psel && penable && pwrite && paddr == OFS_CMD && pwdata[CMD_CLEAR_CAP];
  assign inNow   = {extTripOrderBlock, extBlockInB, extBlockInA};
  always_comb begin
    anyHot = 1'b0;
    for (int i = 0; i < N_SENSORS; i++) begin
      if (tempValid[i] && $signed(tempValue[i*TEMP_W +: TEMP_W]) > 0) begin
        anyHot = 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence sSetup;
    psel && !penable;
  endsequence
  sequence sAccess;
    psel && penable;
  endsequence

  AST_APB_READY: assert property (sSetup ##1 sAccess |-> pready)
    else $error("pready low in access phase");
  AST_SLVERR: assert property (psel && penable && paddr > 8'h28 |-> pslverr)
    else $error("no error on unmapped address");
  AST_INPUT_STATES: assert property (!$past(rst) |-> inputStates == $past(inNow))
    else $error("input states do not follow inputs");
  AST_BLOCK_QUIET: assert property (status.externallyBlocked |->
    !(status.alarm || status.trip || status.tripOrder || status.alarmPickup || status.alarmTimeout))
    else $error("output active while blocked");
  AST_TIMEOUT_PICKUP: assert property (status.alarmTimeout |-> status.alarmPickup)
    else $error("timeout without pickup");
  AST_ORDER_GATE: assert property (status.tripOrder |-> status.trip &&
    !status.tripOrderPermBlock && !status.tripOrderExtBlocked)
    else $error("trip order not gated");
  AST_SENSOR: assert property (status.tempSensorInUse |->
    ($past(anyHot) || $past(anyHot, 2)) && ($past(overCur) || $past(overCur, 2)))
    else $error("sensor flag without cause");
  AST_OVERLOAD_LOW: assert property (!$past(overCur) && !$past(overCur, 2)
    |-> !status.overloadAboveServiceFactor)
    else $error("overload flag with low current");
  AST_CAP_RISE: assert property (!$past(rst) && thermalCapacityUsed > $past(thermalCapacityUsed)
    |-> $past(overCur) || $past(overCur, 2))
    else $error("capacity grew with low current");
  AST_CAP_FALL: assert property (!$past(rst) && thermalCapacityUsed < $past(thermalCapacityUsed)
    |-> $past(clrReq) || $past(clrReq, 2))
    else $error("capacity fell without clear");
  AST_PICKUP_LVL: assert property (status.alarmPickup |-> $past(thermalCapacityUsed) >= 17'h01770)
    else $error("pickup below lowest level");
  AST_TRIP_LVL: assert property (status.trip |-> $past(thermalCapacityUsed) >= 17'h01770)
    else $error("trip below lowest level");
endmodule

/* dv/tola_partner.sv */
`timescale 1ns/100ps
module tola_partner
  import tola_pkg::*;
#(
  parameter int TEMP_W = 12
) (
  input  wire logic           clk,
  input  wire logic [15:0]    rnd,
  input  wire logic           load,
  input  wire logic           hot,
  input  wire logic           blkA,
  input  wire logic           blkB,
  input  wire logic           blkT,
  output logic [15:0]         phaseCurrent,
  output logic [1:0]          tempValid,
  output logic [2*TEMP_W-1:0] tempValue,
  output logic                extBlockInA,
  output logic                extBlockInB,
  output logic                extTripOrderBlock
);
  // Current wanders every cycle but stays on the commanded side of the level
  always @(posedge clk) begin
    phaseCurrent <= load ? ULT_LVL_RST + {2'h0, rnd[13:0]} + 16'h0001 : {8'h00, rnd[7:0]};
    // Invalid sensor still carries a positive value to catch a missing valid check
    tempValid    <= {1'b1, hot};
    tempValue    <= {1'b1, rnd[TEMP_W-2:0], 2'h0, rnd[TEMP_W-3:0] | (TEMP_W-2)'(1)};
    extBlockInA       <= blkA;
    extBlockInB       <= blkB;
    extTripOrderBlock <= blkT;
  end
endmodule

/* dv/thermal_overload_alarm_tb.sv */
`timescale 1ns/100ps
module thermal_overload_alarm_tb
  import tola_pkg::*;
();
  typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;} tola_exp_s;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic         psel = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite = 1'b0;
  logic [7:0]   paddr = 8'h00;
  logic [31:0]  pwdata = 32'h0;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic [15:0]  phaseCurrent;
  logic [1:0]   tempValid;
  logic [23:0]  tempValue;
  logic         extBlockInA;
  logic         extBlockInB;
  logic         extTripOrderBlock;
  tola_status_s status;
  logic [2:0]   inputStates;
  logic [16:0]  thermalCapacityUsed;
  logic         irq;
  logic         load = 1'b0;
  logic         hot = 1'b0;
  logic         blkA = 1'b0;
  logic         blkB = 1'b0;
  logic         blkT = 1'b0;
  logic [15:0]  rnd = 16'h0016;
  wire  [13:0]  statusWord = {inputStates, status};
  int           mismatches = 0;
  int           compares = 0;
  int           cycleCnt = 0;
  int           took;
  int           t0;
  tola_exp_s    expQ[$];
  logic [7:0]   rAdr[9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h20, 8'h24, 8'h18};
  logic [31:0]  rVal[9] = '{32'h7, 32'h46, 32'h1, 32'h63, 32'h0, 32'h100, 32'h0, 32'h0, 32'h1};
  logic [7:0]   cAdr[8] = '{8'h04, 8'h08, 8'h0c, 8'h08, 8'h04, 8'h10, 8'h10, 8'h14};
  logic [31:0]  cIn[8]  = '{32'h10, 32'h200, 32'h70, 32'h0, 32'h46, 32'h10000, 32'h0, 32'h10100};
  logic [31:0]  cOut[8] = '{32'h3c, 32'h168, 32'h63, 32'h1, 32'h46, 32'h8ca0, 32'h0, 32'h100};

  tola_top #(.TICK_CYC(1), .CAP_STEP(17'h00400)) dut (
    .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .phaseCurrent, .tempValid, .tempValue, .extBlockInA, .extBlockInB, .extTripOrderBlock,
    .status, .inputStates, .thermalCapacityUsed, .irq
  );
  tola_partner #(.TEMP_W(12)) farSide (
    .clk, .rnd, .load, .hot, .blkA, .blkB, .blkT, .phaseCurrent, .tempValid, .tempValue,
    .extBlockInA, .extBlockInB, .extTripOrderBlock
  );

  // ---------------------------------------------------------------
  // Clock, random source, checking
  // ---------------------------------------------------------------
  always #10 clk = ~clk;
  function automatic logic [15:0] lfsrNext(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  always @(posedge clk) begin
    rnd      <= lfsrNext(rnd);
    cycleCnt <= cycleCnt + 1;
  end
  task automatic checkWord(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  always @(posedge clk) begin
    tola_exp_s n;
    if (psel && penable && pready === 1'b1 && !pwrite && expQ.size() > 0) begin
      n = expQ.pop_front();
      checkWord("read data", n.d & n.m, prdata & n.m);
      checkWord("slave error", {31'h0, n.e}, {31'h0, pslverr});
    end
  end

  // ---------------------------------------------------------------
  // Bus and wait tasks
  // ---------------------------------------------------------------
  task automatic apbDo(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic apbRead(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                         input logic e);
    expQ.push_back({d, m, e});
    apbDo(a, 1'b0, 32'h0);
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic waitBit(input int idx, input int lim, output int t);
    t = 0;
    @(negedge clk);
    while (statusWord[idx] !== 1'b1 && t < lim) begin
      @(negedge clk);
      t++;
    end
    checkWord("status wait", 32'h1, {31'h0, statusWord[idx]});
  endtask
  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    repeat (90000) @(posedge clk);
    mismatches++;
    $display("Error watchdog expected finish seen hang");
    report_and_stop();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    foreach (rAdr[i]) apbRead(rAdr[i], rVal[i], 32'hffffffff, 1'b0);
    apbRead(8'h2c, 32'h0, 32'hffffffff, 1'b1);
    foreach (cAdr[i]) begin
      apbDo(cAdr[i], 1'b1, cIn[i]);
      apbRead(cAdr[i], cOut[i], 32'hffffffff, 1'b0);
    end
    $display("test settings done");
    apbDo(8'h00, 1'b1, 32'h043);
    apbDo(8'h20, 1'b1, 32'h01);
    load <= 1'b1;
    hot  <= 1'b1;
    settle(4);
    apbRead(8'h18, 32'h600, 32'h600, 1'b0);
    waitBit(7, 200, took);
    t0 = cycleCnt;
    @(posedge clk);
    load <= 1'b0;
    settle(4);
    checkWord("irq", 32'h1, {31'h0, irq});
    apbRead(8'h18, 32'h081, 32'h3fff, 1'b0);
    apbRead(8'h1c, 32'h09, 32'h1f, 1'b0);
    apbDo(8'h1c, 1'b1, 32'h01);
    settle(2);
    checkWord("irq", 32'h0, {31'h0, irq});
    $display("test pickup done");
    waitBit(8, 61000, took);
    checkWord("delay", 32'h1, {31'h0, (cycleCnt - t0) inside {[59990:60010]}});
    apbRead(8'h18, 32'h191, 32'h3fff, 1'b0);
    $display("test alarm delay done");
    apbDo(8'h00, 1'b1, 32'h0cb);
    blkA <= 1'b1;
    settle(3);
    apbRead(8'h18, 32'h802, 32'h3ffe, 1'b0);
    @(posedge clk);
    blkA <= 1'b0;
    blkB <= 1'b1;
    settle(3);
    apbRead(8'h18, 32'h1081, 32'h3fff, 1'b0);
    $display("test blocking done");
    apbDo(8'h00, 1'b1, 32'h227);
    blkB <= 1'b0;
    blkT <= 1'b1;
    load <= 1'b1;
    waitBit(5, 200, took);
    @(posedge clk);
    load <= 1'b0;
    settle(3);
    apbRead(8'h18, 32'h20a8, 32'h21f8, 1'b0);
    @(posedge clk);
    blkT <= 1'b0;
    settle(3);
    apbRead(8'h18, 32'h0060, 32'h2068, 1'b0);
    apbDo(8'h00, 1'b1, 32'h235);
    settle(2);
    apbRead(8'h18, 32'h0024, 32'h0064, 1'b0);
    $display("test trip order done");
    apbDo(8'h28, 1'b1, 32'h1);
    apbDo(8'h24, 1'b1, 32'h1234);
    apbRead(8'h24, 32'h0, 32'hffffffff, 1'b0);
    settle(1);
    checkWord("capacity", 32'h0, 32'(thermalCapacityUsed));
    apbRead(8'h18, 32'h0, 32'h0060, 1'b0);
    $display("test clear done");
    report_and_stop();
  end
endmodule

bind tola_top tola_assertions #(.N_SENSORS(N_SENSORS), .TEMP_W(TEMP_W), .CUR_W(CUR_W)) uChk (
  .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .phaseCurrent,
  .tempValid, .tempValue, .extBlockInA, .extBlockInB, .extTripOrderBlock, .status,
  .inputStates, .thermalCapacityUsed
);
